// File: hw/lhb_consts.svh
// constants for the display host bus interface
`ifndef LHB_CONSTS_SVH
`define LHB_CONSTS_SVH
`define LHB_DATA_W      8
`define LHB_BIT_CNT_W   3
`define LHB_LAST_BIT    3'h7
`define LHB_MSB_POS     7
`define LHB_FIFO_DEPTH  4
`define LHB_BYTE_RST    8'h00
`define LHB_RS_RAM      1'b0
`define LHB_RS_REG      1'b1
`endif

// File: hw/lhb_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module lhb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("lhb_fifo depth must be a power of two of at least 2");
    end
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;
  assign full        = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty       = (wr_q == rd_q);
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign push        = i_in_valid && !full;
  assign pop         = i_out_ready && !empty;
  assign o_out_data  = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= i_in_data;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
endmodule // lhb_fifo

// File: hw/lhb_host_port.sv
// host port of the display controller: parallel 80-style bus or serial link
// ==========================================================================
// What this block does
// [R01] strap high picks the parallel port; strap low picks the write-only serial port
// [R02] host keeps serial clock and data steady while parallel port is in use
// [R03] in serial mode data bus stays released and read/write strobes are ignored
// [R04] register-select level is captured with every transfer to classify the byte
// [R05] parallel mode: a low write strobe takes the bus byte as a write
// [R06] parallel mode: read byte is driven onto the bus while read strobe is low
// [R07] serial mode: one data bit shifted in on each serial clock rise
// [R08] serial mode: eighth serial clock rise hands a whole byte to internal logic
// [R09] host returns serial clock low after a transfer and while idle
// [R10] external reset pin resets the whole controller
// [R11] chip select held low over every transfer; activity ignored while high
// [R12] register-select low means display memory data, high means register access
// [R13] serial bit counter cleared whenever chip select goes high
// [R14] serial bytes arrive msb first; first bit lands in bit 7
`timescale 1ns/1ps
`include "lhb_consts.svh"
module lhb_host_port #(
  parameter int FIFO_DEPTH = `LHB_FIFO_DEPTH
) (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_sys_rst,
  input  wire logic                 i_module_reset_in_n,
  input  wire logic                 i_chip_select_bar_n,
  input  wire logic                 i_register_select,
  input  wire logic                 i_par_ser_sel,
  input  wire logic                 i_write_n,
  input  wire logic                 i_read_n,
  input  wire lhb_pkg::lhb_byte_type i_parallel_data_bus,
  output lhb_pkg::lhb_byte_type     o_parallel_data_bus,
  output logic                      o_parallel_data_bus_oe_n,
  input  wire logic                 i_serial_clk,
  input  wire logic                 i_serial_data,
  output logic                      o_wr_valid,
  input  wire logic                 i_wr_ready,
  output lhb_pkg::lhb_byte_type     o_wr_data,
  output logic                      o_wr_is_reg,
  output logic                      o_rd_req,
  output logic                      o_rd_is_reg,
  input  wire lhb_pkg::lhb_byte_type i_rd_data,
  output logic                      o_ctrl_rst,
  output logic                      o_overrun
);
  import lhb_pkg::*;
  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("lhb_host_port needs a fifo of at least two words");
    end
  end

  // ========================================================================
  // pin synchronisers: every pin passes two flops before logic reads it
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_m_q;
  logic [NPIN-1:0] pin_s_q;
  lhb_byte_type    bus_m_q;
  lhb_byte_type    bus_s_q;
  assign pin_raw = {i_module_reset_in_n, i_chip_select_bar_n, i_register_select,
                    i_par_ser_sel, i_write_n, i_read_n, i_serial_clk};
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pin_m_q <= 7'h7E;
      pin_s_q <= 7'h7E;
      bus_m_q <= `LHB_BYTE_RST;
      bus_s_q <= `LHB_BYTE_RST;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
      bus_m_q <= i_parallel_data_bus;
      bus_s_q <= bus_m_q;
    end
  end
  logic sd_m_q;
  logic sd_s_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      sd_m_q <= 1'b0;
      sd_s_q <= 1'b0;
    end else begin
      sd_m_q <= i_serial_data;
      sd_s_q <= sd_m_q;
    end
  end

  wire rstin_n = pin_s_q[6];
  wire cs_n    = pin_s_q[5];
  wire rs_s    = pin_s_q[4];
  wire par_sel = pin_s_q[3];
  wire wr_n_s  = pin_s_q[2];
  wire rd_n_s  = pin_s_q[1];
  wire sclk_s  = pin_s_q[0];

  // ========================================================================
  // controller reset: the pin resets all port state after the pin synchronisers and is passed on
  wire ctl_rst = i_sys_rst || !rstin_n; // R10
  assign o_ctrl_rst = ctl_rst; // R10

  // ========================================================================
  // edge finding on synchronised strobes and serial clock
  logic wr_n_d1_q;
  logic rd_n_d1_q;
  logic sclk_d1_q;
  always_ff @(posedge i_sys_clk) begin
    if (ctl_rst) begin
      wr_n_d1_q <= 1'b1;
      rd_n_d1_q <= 1'b1;
      sclk_d1_q <= 1'b0;
    end else begin
      wr_n_d1_q <= wr_n_s;
      rd_n_d1_q <= rd_n_s;
      sclk_d1_q <= sclk_s;
    end
  end
  wire par_mode = par_sel;                               // R01
  wire ser_mode = !par_sel;                              // R01
  wire sel_ok   = !cs_n;                                 // R11
  // write taken on the strobe's fall; the data was set up before it
  wire wr_fall  = par_mode && sel_ok && wr_n_d1_q && !wr_n_s;  // R05 R03
  wire rd_fall  = par_mode && sel_ok && rd_n_d1_q && !rd_n_s;  // R06 R03
  wire rd_hold  = par_mode && sel_ok && !rd_n_s;               // R06
  // serial clock is only looked at in serial mode, so a parked clock is harmless
  wire sclk_rise = ser_mode && sel_ok && !sclk_d1_q && sclk_s; // R07 R02

  // ========================================================================
  // serial shift register and bit counter
  logic [`LHB_BIT_CNT_W-1:0] bit_cnt_q;
  logic [`LHB_BIT_CNT_W-1:0] bit_cnt_d;
  lhb_byte_type              shift_q;
  lhb_byte_type              shift_d;
  assign shift_d   = {shift_q[`LHB_MSB_POS-1:0], sd_s_q};       // R14
  assign bit_cnt_d = bit_cnt_q + `LHB_BIT_CNT_W'(1);
  wire ser_done    = sclk_rise && (bit_cnt_q == `LHB_LAST_BIT); // R08
  always_ff @(posedge i_sys_clk) begin
    if (ctl_rst || cs_n || par_mode) begin
      bit_cnt_q <= '0;                                          // R13
    end else if (sclk_rise) begin
      bit_cnt_q <= bit_cnt_d;                                   // R07
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (ctl_rst) begin
      shift_q <= `LHB_BYTE_RST;
    end else if (sclk_rise) begin
      shift_q <= shift_d;                                       // R07
    end
  end

  // ========================================================================
  // write path: either port feeds the fifo with {register_select, byte}
  logic        push_valid;
  logic        push_ready;
  logic [8:0]  push_word;
  logic [8:0]  pop_word;
  assign push_valid = wr_fall || ser_done;
  // the register-select level is taken at the same instant as the byte
  assign push_word  = ser_done ? {rs_s, shift_d} : {rs_s, bus_s_q}; // R04 R08
  lhb_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_sys_rst   (ctl_rst),
    .i_in_valid  (push_valid),
    .o_in_ready  (push_ready),
    .i_in_data   (push_word),
    .o_out_valid (o_wr_valid),
    .i_out_ready (i_wr_ready),
    .o_out_data  (pop_word)
  );
  assign o_wr_data   = pop_word[7:0];
  assign o_wr_is_reg = (pop_word[8] == `LHB_RS_REG); // R12

  // the host has no wait line, so a byte arriving into a full fifo is lost
  logic overrun_q;
  always_ff @(posedge i_sys_clk) begin
    if (ctl_rst) begin
      overrun_q <= 1'b0;
    end else if (push_valid && !push_ready) begin
      overrun_q <= 1'b1;
    end
  end
  assign o_overrun = overrun_q;

  // ========================================================================
  // read path: request on the strobe's fall, drive the bus while held low
  logic         rd_req_q;
  logic         rd_is_reg_q;
  logic         drive_q;
  lhb_byte_type rd_byte_q;
  always_ff @(posedge i_sys_clk) begin
    if (ctl_rst) begin
      rd_req_q    <= 1'b0;
      rd_is_reg_q <= 1'b0;
    end else begin
      rd_req_q    <= rd_fall;                                   // R06
      rd_is_reg_q <= rd_fall ? (rs_s == `LHB_RS_REG) : rd_is_reg_q; // R04 R12
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (ctl_rst) begin
      rd_byte_q <= `LHB_BYTE_RST;
      drive_q   <= 1'b0;
    end else begin
      rd_byte_q <= rd_req_q ? i_rd_data : rd_byte_q;            // R06
      drive_q   <= rd_hold;                                     // R06 R03
    end
  end
  assign o_rd_req                 = rd_req_q;
  assign o_rd_is_reg              = rd_is_reg_q;
  assign o_parallel_data_bus      = rd_byte_q;
  // low enable drives the bus; released in serial mode and when deselected
  assign o_parallel_data_bus_oe_n = !(drive_q && rd_hold);      // R03 R11
endmodule // lhb_host_port

// File: hw/lhb_pkg.sv
// types for the display host bus interface
package lhb_pkg;
  typedef logic [7:0] lhb_byte_type;
  typedef enum logic [1:0] {
    LHB_IDLE  = 2'b00,
    LHB_WRITE = 2'b01,
    LHB_READ  = 2'b10
  } lhb_par_state_type;
endpackage

// File: tb/lhb_host_port_sva.sv
// concurrent checks on the display host port boundary
`timescale 1ns/1ps
module lhb_host_port_sva (
  input wire logic                  i_sys_clk,
  input wire logic                  i_sys_rst,
  input wire logic                  i_module_reset_in_n,
  input wire logic                  i_chip_select_bar_n,
  input wire logic                  i_par_ser_sel,
  input wire logic                  i_wr_ready,
  input wire lhb_pkg::lhb_byte_type i_rd_data,
  input wire lhb_pkg::lhb_byte_type o_parallel_data_bus,
  input wire logic                  o_parallel_data_bus_oe_n,
  input wire logic                  o_wr_valid,
  input wire lhb_pkg::lhb_byte_type o_wr_data,
  input wire logic                  o_rd_req,
  input wire logic                  o_ctrl_rst,
  input wire logic                  o_overrun
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // ==========================================================
  // reset, mode and chip select
  rst_idle_a: assert property ($fell(i_sys_rst) |->
    o_parallel_data_bus_oe_n && !o_wr_valid && !o_overrun) else $error("not idle after reset");
  pin_reset_a: assert property (
    !i_module_reset_in_n [*4] |-> o_ctrl_rst) else $error("reset pin ignored");
  ser_float_a: assert property (
    !i_par_ser_sel [*4] |-> o_parallel_data_bus_oe_n) else $error("bus driven in serial mode");
  ser_noread_a: assert property (
    !i_par_ser_sel [*4] |-> !o_rd_req) else $error("read taken in serial mode");
  cs_ignore_a: assert property (
    i_chip_select_bar_n [*5] |-> !o_rd_req && !$rose(o_wr_valid)) else $error("access while idle");
  // ==========================================================
  // read path and write queue
  rd_drive_a: assert property (
    o_rd_req |-> !o_parallel_data_bus_oe_n) else $error("read not driven");
  rd_data_a: assert property (
    o_rd_req |=> o_parallel_data_bus == $past(i_rd_data)) else $error("read byte wrong");
  rd_pulse_a: assert property (o_rd_req |=> !o_rd_req) else $error("read request too long");
  wr_hold_a: assert property (o_wr_valid && !i_wr_ready && !o_ctrl_rst |=>
    o_wr_valid && $stable(o_wr_data)) else $error("queued byte lost");
  ovr_sticky_a: assert property (o_overrun && !o_ctrl_rst |=> o_overrun) else $error("overrun lost");
endmodule // lhb_host_port_sva
bind lhb_host_port lhb_host_port_sva i_lhb_host_port_sva (.i_sys_clk, .i_sys_rst,
  .i_module_reset_in_n, .i_chip_select_bar_n, .i_par_ser_sel, .i_wr_ready, .i_rd_data,
  .o_parallel_data_bus, .o_parallel_data_bus_oe_n, .o_wr_valid, .o_wr_data, .o_rd_req,
  .o_ctrl_rst, .o_overrun);

// File: tb/lhb_host_port_tb.sv
// self-checking bench for the display host port
`timescale 1ns/1ps
module lhb_host_port_tb;
  import lhb_pkg::*;
  logic         clk, rst, res_n, sel, rdy, cs_n, rs, wr_n, rd_n, sclk, sdat;
  logic         oe_n, vld, is_reg, rd_req, rd_is_reg, crst, ovr;
  lhb_byte_type bus_m, bus_o, bus_w, wdat, rdat, got;
  int           n_fail = 0;
  int           num_checks = 0;
  assign bus_w = oe_n ? bus_m : bus_o;
  lhb_host_port i_lhb_host_port (.i_sys_clk(clk), .i_sys_rst(rst), .i_module_reset_in_n(res_n),
    .i_chip_select_bar_n(cs_n), .i_register_select(rs), .i_par_ser_sel(sel), .i_write_n(wr_n),
    .i_read_n(rd_n), .i_parallel_data_bus(bus_w), .o_parallel_data_bus(bus_o),
    .o_parallel_data_bus_oe_n(oe_n), .i_serial_clk(sclk), .i_serial_data(sdat),
    .o_wr_valid(vld), .i_wr_ready(rdy), .o_wr_data(wdat), .o_wr_is_reg(is_reg),
    .o_rd_req(rd_req), .o_rd_is_reg(rd_is_reg), .i_rd_data(rdat), .o_ctrl_rst(crst),
    .o_overrun(ovr));
  lhb_mpu_model i_lhb_mpu_model (.i_sys_clk(clk), .i_bus(bus_w), .o_cs_n(cs_n), .o_rs(rs),
    .o_wr_n(wr_n), .o_rd_n(rd_n), .o_bus(bus_m), .o_sclk(sclk), .o_sdat(sdat));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk8(input string nm, input lhb_byte_type e, input lhb_byte_type g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // bounded wait for the queue head, then one-cycle pop
  task automatic pop(input logic r, input lhb_byte_type d);
    // look away from the edge that may have just popped the previous head
    @(negedge clk);
    for (int k = 0; k < 60 && vld !== 1'b1; k++) @(negedge clk);
    chk8("wr_valid", 8'h01, {7'h00, vld});
    chk8("wr_data", d, wdat);
    chk8("wr_is_reg", {7'h00, r}, {7'h00, is_reg});
    @(posedge clk);
    rdy <= 1'b1;
    @(posedge clk);
    rdy <= 1'b0;
  endtask
  task automatic t_fifo;
    for (int i = 0; i < 5; i++) i_lhb_mpu_model.par_write(1'b0, 1'b0, 8'h10 + 8'(i));
    @(negedge clk);
    chk8("overrun", 8'h01, {7'h00, ovr});
    for (int i = 0; i < 4; i++) pop(1'b0, 8'h10 + 8'(i));
    @(negedge clk);
    chk8("wr_valid", 8'h00, {7'h00, vld});
    @(posedge clk);
  endtask
  task automatic t_rst;
    res_n <= 1'b0;
    repeat (5) @(negedge clk);
    chk8("ctrl_rst", 8'h01, {7'h00, crst});
    chk8("overrun", 8'h00, {7'h00, ovr});
    @(posedge clk);
    res_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_par;
    i_lhb_mpu_model.par_write(1'b0, 1'b0, 8'hA5);
    pop(1'b0, 8'hA5);
    i_lhb_mpu_model.par_write(1'b0, 1'b1, 8'h3C);
    pop(1'b1, 8'h3C);
    i_lhb_mpu_model.par_write(1'b1, 1'b0, 8'h66);
    chk8("wr_valid", 8'h00, {7'h00, vld});
    rdat <= 8'hC3;
    i_lhb_mpu_model.par_read(1'b1, got);
    chk8("read_bus", 8'hC3, got);
    chk8("rd_is_reg", 8'h01, {7'h00, rd_is_reg});
  endtask
  task automatic t_ser;
    sel <= 1'b0;
    repeat (6) @(posedge clk);
    i_lhb_mpu_model.ser_byte(1'b0, 8'h96, 8);
    pop(1'b0, 8'h96);
    i_lhb_mpu_model.ser_byte(1'b1, 8'hFF, 3);
    i_lhb_mpu_model.ser_byte(1'b1, 8'h5A, 8);
    pop(1'b1, 8'h5A);
    i_lhb_mpu_model.par_write(1'b0, 1'b0, 8'h77);
    i_lhb_mpu_model.par_read(1'b0, got);
    chk8("wr_valid", 8'h00, {7'h00, vld});
    chk8("oe_n", 8'h01, {7'h00, oe_n});
    chk8("read_bus_float", 8'h88, got);
  endtask
  initial begin
    {rst, res_n, sel, rdy, rdat} = {4'b1110, 8'h00};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_fifo();
    t_rst();
    t_par();
    t_ser();
    tally_and_finish();
  end
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
endmodule // lhb_host_port_tb

// File: tb/lhb_mpu_model.sv
// host microprocessor model driving the display host port pins
`timescale 1ns/1ps
module lhb_mpu_model (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_bus,
  output logic            o_cs_n,
  output logic            o_rs,
  output logic            o_wr_n,
  output logic            o_rd_n,
  output logic [7:0]      o_bus,
  output logic            o_sclk,
  output logic            o_sdat
);
  // serial pins parked low while the parallel port is in use
  initial begin
    {o_cs_n, o_rs, o_wr_n, o_rd_n, o_bus, o_sclk, o_sdat} = {1'b1, 1'b0, 1'b1, 1'b1, 8'h00, 2'b00};
  end
  task automatic par_write(input logic cs_n, input logic rs, input logic [7:0] d);
    {o_cs_n, o_rs, o_bus, o_wr_n} <= {cs_n, rs, d, 1'b0};
    repeat (4) @(posedge i_sys_clk);
    o_wr_n <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    {o_cs_n, o_bus} <= {1'b1, ~d};
    @(posedge i_sys_clk);
  endtask
  task automatic par_read(input logic rs, output logic [7:0] d);
    {o_cs_n, o_rs, o_rd_n} <= {1'b0, rs, 1'b0};
    repeat (7) @(posedge i_sys_clk);
    d = i_bus;
    o_rd_n <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    o_cs_n <= 1'b1;
    @(posedge i_sys_clk);
  endtask
  // msb first, 4 sys cycles per phase gives the 80 ns shift clock
  task automatic ser_byte(input logic rs, input logic [7:0] d, input int n);
    {o_cs_n, o_rs} <= {1'b0, rs};
    for (int i = 7; i > 7 - n; i--) begin
      o_sdat <= d[i];
      repeat (4) @(posedge i_sys_clk);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_sys_clk);
    {o_cs_n, o_sdat} <= {1'b1, ~o_sdat};
    @(posedge i_sys_clk);
  endtask
endmodule // lhb_mpu_model
